// File: logic/banked_memory_map_map.svh
// Address map constants for the banked memory map block
`ifndef BANKED_MEMORY_MAP_MAP_SVH
`define BANKED_MEMORY_MAP_MAP_SVH

`define PC_W            13
`define PROG_ADDR_W     12
`define PROG_DATA_W     14
`define RESET_VECTOR    13'h0000
`define IRQ_VECTOR      13'h0004
`define DATA_W          8
`define DADDR_W         9
`define OFFSET_W        7
`define RAM_ADDR_W      8
`define RAM_DEPTH       256
`define SFR_TOP         7'h1F
`define OFS_INDIRECT    7'h00
`define OFS_PCL         7'h02
`define OFS_STATUS      7'h03
`define OFS_POINTER     7'h04
`define OFS_PCLATH      7'h0A
`define OFS_INTCON      7'h0B
`define OFS_SHARED_LO   7'h70
`define STATUS_BSL_BIT  5
`define STATUS_BSH_BIT  6
`define STATUS_IRP_BIT  7
`define STATUS_RST      8'h18

`endif

// File: logic/banked_memory_map_pkg.sv
// Types for the banked memory map block
package banked_memory_map_pkg;
    typedef enum logic [1:0] {
        BANK_0,
        BANK_1,
        BANK_2,
        BANK_3
    } bank_e;

    typedef enum logic [1:0] {
        AREA_INDIRECT,
        AREA_CORE,
        AREA_SPECIAL,
        AREA_GENERAL
    } area_e;
endpackage

// File: logic/data_ram.sv
// General purpose static RAM, 256 x 8, registered read data
`timescale 1ns/1ps
`include "banked_memory_map_map.svh"

module data_ram (
    input  wire logic                     i_clk,    // Core clock
    input  wire logic                     i_we,     // Write strobe
    input  wire logic [`RAM_ADDR_W-1:0]   i_addr,   // Word address
    input  wire logic [`DATA_W-1:0]       i_wdata,    // Write data
    input  wire logic                     i_alt_sel,  // Return alt word
    input  wire logic [`DATA_W-1:0]       i_alt_data, // Non-RAM word
    output logic      [`DATA_W-1:0]       o_rdata     // Registered read data
);
    logic [`DATA_W-1:0] mem [`RAM_DEPTH];

    // Plain synchronous RAM, no reset so it maps to block memory
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
    end

    // Core and refused reads share the output register, so read data
    // leave the block from a flop with the same latency as RAM data
    always_ff @(posedge i_clk) begin
        if (i_alt_sel) begin
            o_rdata <= i_alt_data;
        end else begin
            o_rdata <= mem[i_addr];
        end
    end
endmodule

// File: logic/banked_memory_map.sv
// Program counter and banked data address mapping for the core
`timescale 1ns/1ps
`include "banked_memory_map_map.svh"

// ****************************************************************
// Notes on behaviour
// - The program counter is 13 bits and program memory is 4K x 14.
// - Fetch addresses past 4K wrap into the first 4K words.
// - After reset the first fetch is from address zero.
// - Taking an interrupt loads the program counter with four.
// - The high and low bank-select bits pick bank 0 to 3 in binary.
// - Each bank spans offsets 00h through 7Fh, 128 bytes.
// - Low offsets decode as special function area, higher as RAM.
// - Core registers and the top shared RAM are mirrored in all banks.
// - The data register file is 256 locations of 8 bits.
// - Data is reached by direct offset or via the indirect pointer.
// ****************************************************************

module banked_memory_map (
    input  wire logic                   i_clk,         // Core clock
    input  wire logic                   i_reset_n,     // Async reset
    input  wire logic                   i_pc_advance,  // Step PC by one
    input  wire logic                   i_pc_load,     // Jump request
    input  wire logic [`PC_W-1:0]       i_pc_target,   // Jump target
    input  wire logic                   i_irq_take,    // Interrupt taken
    input  wire logic                   i_data_rd,     // Data read strobe
    input  wire logic                   i_data_wr,     // Data write strobe
    input  wire logic                   i_indirect,    // Use pointer
    input  wire logic [`OFFSET_W-1:0]   i_offset,      // Direct offset
    input  wire logic [`DATA_W-1:0]     i_wdata,       // Write data
    output logic      [`PC_W-1:0]       o_pc,          // Program counter
    output logic      [`PROG_ADDR_W-1:0] o_fetch_addr, // Wrapped fetch
    output logic      [`DADDR_W-1:0]    o_data_addr,   // Full data addr
    output logic      [1:0]             o_area,        // Decoded area
    output logic      [1:0]             o_bank,        // Active bank
    output logic      [`DATA_W-1:0]     o_rdata,       // Read data
    output logic                        o_rvalid,      // Read data valid
    output logic                        o_sfr_wr,      // Peripheral write
    output logic      [`DATA_W-1:0]     o_indirect_pointer // Pointer value
);
    // ************************************************************
    // Program counter
    // ************************************************************
    logic [`PC_W-1:0] pc_r;
    logic [`PC_W-1:0] pc_nxt;

    // Interrupt outranks a jump, which outranks a plain step
    always_comb begin
        pc_nxt = pc_r;
        if (i_irq_take) begin
            pc_nxt = `IRQ_VECTOR;
        end else if (i_pc_load) begin
            pc_nxt = i_pc_target;
        end else if (i_pc_advance) begin
            pc_nxt = pc_r + 13'h0001;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pc_r <= `RESET_VECTOR;
        end else begin
            pc_r <= pc_nxt;
        end
    end

    // Output loads the next value at the same edge as the counter,
    // so a reader never sees it one cycle late
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_pc <= `RESET_VECTOR;
        end else begin
            o_pc <= pc_nxt;
        end
    end

    // Only the low 12 bits reach program memory, so a jump past 4K
    // lands back in the first 4K words
    // fetch wraps at 4K
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_fetch_addr <= 12'h000;
        end else begin
            o_fetch_addr <= pc_nxt[`PROG_ADDR_W-1:0];
        end
    end

    // ************************************************************
    // Core registers held by this block
    // ************************************************************
    logic [`DATA_W-1:0] status_r;
    logic [`DATA_W-1:0] pointer_r;
    logic [`DATA_W-1:0] pclath_r;
    logic [`DATA_W-1:0] intcon_r;

    // ************************************************************
    // Address formation and decode
    // ************************************************************
    logic [`DADDR_W-1:0]    addr_full;
    logic [`OFFSET_W-1:0]   ofs;
    logic [1:0]             bank_sel;
    banked_memory_map_pkg::area_e area;
    logic [`RAM_ADDR_W-1:0] ram_addr;
    logic                   ram_hit;

    // Area of an in-bank offset; shared by both address paths
    function automatic banked_memory_map_pkg::area_e area_of(
        input logic [`OFFSET_W-1:0] o
    );
        if (o == `OFS_INDIRECT) begin
            return banked_memory_map_pkg::AREA_INDIRECT;
        end else if (o == `OFS_PCL || o == `OFS_STATUS ||
                     o == `OFS_POINTER || o == `OFS_PCLATH ||
                     o == `OFS_INTCON) begin
            return banked_memory_map_pkg::AREA_CORE;
        end else if (o <= `SFR_TOP) begin
            return banked_memory_map_pkg::AREA_SPECIAL;
        end else begin
            return banked_memory_map_pkg::AREA_GENERAL;
        end
    endfunction

    // bank bits as a binary pair
    assign bank_sel = {status_r[`STATUS_BSH_BIT],
                       status_r[`STATUS_BSL_BIT]};

    // Indirect uses the pointer plus the upper bank bit
    always_comb begin
        if (i_indirect) begin
            addr_full = {status_r[`STATUS_IRP_BIT], pointer_r};
        end else begin
            // bank bits above the 7-bit offset
            addr_full = {bank_sel, i_offset};
        end
    end

    assign ofs  = addr_full[`OFFSET_W-1:0];
    assign area = area_of(ofs);

    // fold four banks onto 256 RAM bytes; shared top is common
    always_comb begin
        ram_hit = (area == banked_memory_map_pkg::AREA_GENERAL);
        if (ofs >= `OFS_SHARED_LO) begin
            // top 16 bytes mirror bank 0
            ram_addr = {1'b0, ofs};
        end else begin
            ram_addr = {addr_full[7], ofs};
        end
    end

    // Indirect access through the pointer at offset zero reads zero
    logic access_ok;
    assign access_ok = !(i_indirect &&
                         area == banked_memory_map_pkg::AREA_INDIRECT);

    // ************************************************************
    // Core register writes
    // ************************************************************
    logic core_wr;
    assign core_wr = i_data_wr && access_ok &&
                     (area == banked_memory_map_pkg::AREA_CORE);

    // Offset match gated by the write strobe; every core register
    // and the pointer output use the same test
    function automatic logic wr_hit(
        input logic                 wr,
        input logic [`OFFSET_W-1:0] o,
        input logic [`OFFSET_W-1:0] want
    );
        return wr && (o == want);
    endfunction

    // Reset value leaves bank 0 selected for the first direct accesses
    // status mirrored in all banks
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            status_r <= `STATUS_RST;
        end else if (wr_hit(core_wr, ofs, `OFS_STATUS)) begin
            status_r <= i_wdata;
        end
    end

    // Full 8-bit pointer; the upper bank bit comes from status
    // pointer register
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pointer_r <= 8'h00;
        end else if (wr_hit(core_wr, ofs, `OFS_POINTER)) begin
            pointer_r <= i_wdata;
        end
    end

    // Latch only: jumps take their whole target from the core, so
    // this register is kept for software to read back
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pclath_r <= 8'h00;
        end else if (wr_hit(core_wr, ofs, `OFS_PCLATH)) begin
            pclath_r <= i_wdata;
        end
    end

    // Interrupt enables are held here; the interrupt logic is elsewhere
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            intcon_r <= 8'h00;
        end else if (wr_hit(core_wr, ofs, `OFS_INTCON)) begin
            intcon_r <= i_wdata;
        end
    end

    // ************************************************************
    // General purpose RAM and read data
    // ************************************************************
    logic [`DATA_W-1:0] core_rd;
    logic               alt_sel;
    logic [`DATA_W-1:0] alt_data;

    // Core register value at the current offset; the program counter
    // low byte is live, so a read shows the counter at the strobe
    always_comb begin
        unique case (ofs)
            `OFS_PCL:     core_rd = pc_r[7:0];
            `OFS_STATUS:  core_rd = status_r;
            `OFS_POINTER: core_rd = pointer_r;
            `OFS_PCLATH:  core_rd = pclath_r;
            `OFS_INTCON:  core_rd = intcon_r;
            default:      core_rd = 8'h00;
        endcase
    end

    // Anything but an allowed RAM hit returns the alternate word
    assign alt_sel = !(access_ok && ram_hit);

    // Peripheral special area reads zero here; peripherals own it
    always_comb begin
        alt_data = 8'h00;
        if (access_ok && area == banked_memory_map_pkg::AREA_CORE) begin
            alt_data = core_rd;
        end
    end

    // The RAM output register carries core words as well, so the top
    // level read data come straight from a flop
    data_ram u_ram (
        .i_clk      (i_clk),
        .i_we       (i_data_wr && ram_hit && access_ok),
        .i_addr     (ram_addr),
        .i_wdata    (i_wdata),
        .i_alt_sel  (alt_sel),
        .i_alt_data (alt_data),
        .o_rdata    (o_rdata)
    );

    // Strobe delayed one edge to line up with the RAM output register
    // one-cycle read valid
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_data_rd;
        end
    end

    // ************************************************************
    // Registered address and status outputs
    // ************************************************************
    // address, area and bank of the access formed this cycle
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_data_addr <= 9'h000;
            o_area      <= 2'h0;
            o_bank      <= 2'h0;
        end else begin
            o_data_addr <= addr_full;
            o_area      <= area;
            o_bank      <= addr_full[8:7];
        end
    end

    // Peripheral special offsets live outside this block, so a write
    // to them is only flagged here
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_sfr_wr <= 1'b0;
        end else begin
            o_sfr_wr <= i_data_wr && access_ok &&
                (area == banked_memory_map_pkg::AREA_SPECIAL);
        end
    end

    // Pointer output includes a write landing at this edge, so the
    // core sees the new value as soon as the register holds it
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_indirect_pointer <= 8'h00;
        end else begin
            o_indirect_pointer <= wr_hit(core_wr, ofs, `OFS_POINTER) ?
                                  i_wdata : pointer_r;
        end
    end
endmodule

// File: bench/banked_memory_map_asserts.sv
// Concurrent checks on the banked memory map ports
`timescale 1ns/1ps
`include "banked_memory_map_map.svh"

module banked_memory_map_asserts (
    input wire logic                    i_clk,              // Clock
    input wire logic                    i_reset_n,          // Reset
    input wire logic                    i_pc_advance,       // Step
    input wire logic                    i_pc_load,          // Jump
    input wire logic [`PC_W-1:0]        i_pc_target,        // Target
    input wire logic                    i_irq_take,         // Interrupt
    input wire logic                    i_data_rd,          // Read
    input wire logic                    i_data_wr,          // Write
    input wire logic                    i_indirect,         // Pointer mode
    input wire logic [`OFFSET_W-1:0]    i_offset,           // Offset
    input wire logic [`PC_W-1:0]        o_pc,               // PC
    input wire logic [`PROG_ADDR_W-1:0] o_fetch_addr,       // Fetch
    input wire logic [`DADDR_W-1:0]     o_data_addr,        // Data addr
    input wire logic [1:0]              o_area,             // Area
    input wire logic [1:0]              o_bank,             // Bank
    input wire logic                    o_rvalid,           // Valid
    input wire logic                    o_sfr_wr,           // Periph write
    input wire logic [`DATA_W-1:0]      o_indirect_pointer  // Pointer
);
    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    wire logic acc = i_data_rd || i_data_wr;

    reset_pc_zero_a: assert property ($rose(i_reset_n) |-> o_pc == 0)
        else $error("pc not zero after reset");
    irq_vector_a: assert property (i_irq_take |=> o_pc == `IRQ_VECTOR)
        else $error("interrupt vector not loaded");
    pc_jump_a: assert property (i_pc_load && !i_irq_take
        |=> o_pc == $past(i_pc_target)) else $error("jump target lost");
    pc_step_a: assert property (i_pc_advance && !i_pc_load
        && !i_irq_take |=> o_pc == 13'($past(o_pc) + 13'h1))
        else $error("pc step wrong");
    fetch_wrap_a: assert property (o_fetch_addr == o_pc[11:0])
        else $error("fetch address not wrapped");
    read_valid_a: assert property (1'b1 |=> o_rvalid == $past(i_data_rd))
        else $error("read valid timing wrong");
    direct_addr_a: assert property (acc && !i_indirect
        |=> o_data_addr[6:0] == $past(i_offset)
        && o_bank == o_data_addr[8:7])
        else $error("direct address wrong");
    area_decode_a: assert property (acc
        |=> (o_area == 2'h3) == (o_data_addr[6:0] > `SFR_TOP))
        else $error("area decode wrong");
    pointer_addr_a: assert property (acc && i_indirect
        |=> o_data_addr[7:0] == $past(o_indirect_pointer))
        else $error("indirect address wrong");
    cover property (i_irq_take);
    cover property (o_rvalid && o_area == 2'h3);
    sfr_write_a: assert property (o_sfr_wr |-> o_area == 2'h2)
        else $error("peripheral write outside special area");
    cover property (acc && i_indirect);
    cover property (o_sfr_wr);
endmodule

bind banked_memory_map banked_memory_map_asserts u_chk (.*);

// File: bench/core_model.sv
// CPU core model issuing fetch and data requests
`timescale 1ns/1ps
`include "banked_memory_map_map.svh"

module core_model (
    input  wire logic                  i_clk,  // Core clock
    output logic                       o_adv,  // PC step
    output logic                       o_ld,   // Jump
    output logic                       o_irq,  // Interrupt taken
    output logic                       o_rd,   // Read strobe
    output logic                       o_wr,   // Write strobe
    output logic                       o_ind,  // Pointer mode
    output logic [`PC_W-1:0]           o_tgt,  // Jump target
    output logic [`OFFSET_W-1:0]       o_ofs,  // Offset
    output logic [`DATA_W-1:0]         o_wd    // Write data
);
    // Quiet at time zero so reset sees no requests
    initial begin
        {o_adv, o_ld, o_irq, o_rd, o_wr, o_ind} = 6'h00;
        o_tgt = '0;
        o_ofs = '0;
        o_wd  = '0;
    end

    // One request held for one edge, then an idle edge
    task automatic op(input logic [5:0] f, input logic [12:0] t,
                      input logic [6:0] a, input logic [7:0] d);
        @(posedge i_clk);
        {o_adv, o_ld, o_irq, o_rd, o_wr, o_ind} <= f;
        o_tgt <= t;
        o_ofs <= a;
        o_wd  <= d;
        @(posedge i_clk);
        {o_adv, o_ld, o_irq, o_rd, o_wr, o_ind} <= 6'h00;
        // Released fields invert so stale values are never trusted
        o_tgt <= ~t;
        o_ofs <= ~a;
        o_wd  <= ~d;
    endtask
endmodule

// File: bench/banked_memory_map_tb.sv
// Self-checking bench for the banked memory map
`timescale 1ns/1ps
`include "banked_memory_map_map.svh"

module banked_memory_map_tb;
    logic                   i_clk = 1'b0;
    logic                   i_reset_n = 1'b0;
    logic                   adv, ld, irq, rd, wr, ind, rvalid, sfr_wr;
    logic [`PC_W-1:0]       tgt, o_pc;
    logic [`OFFSET_W-1:0]   ofs;
    logic [`DATA_W-1:0]     wd, rdata, ptr_o, ptr, d;
    logic [11:0]            fetch;
    logic [8:0]             daddr;
    logic [1:0]             area, bank;
    logic                   bsl;
    logic [7:0]             mem [256];
    logic [7:0]             exp_q [$];
    int                     err_total = 0;
    int                     samples_checked = 0;
    logic [5:0]  pf [6] = '{6'h20, 6'h10, 6'h20, 6'h10, 6'h38, 6'h20};
    logic [12:0] pt [6] = '{0, 13'h1FFF, 0, 13'h1005, 13'h0123, 0};
    logic [12:0] pe [6] = '{1, 13'h1FFF, 0, 13'h1005, `IRQ_VECTOR, 5};

    always #2 i_clk = ~i_clk;

    core_model u_core (.i_clk(i_clk), .o_adv(adv), .o_ld(ld), .o_irq(irq),
        .o_rd(rd), .o_wr(wr), .o_ind(ind), .o_tgt(tgt), .o_ofs(ofs),
        .o_wd(wd));

    banked_memory_map dut (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_pc_advance(adv), .i_pc_load(ld), .i_pc_target(tgt),
        .i_irq_take(irq), .i_data_rd(rd), .i_data_wr(wr), .i_indirect(ind),
        .i_offset(ofs), .i_wdata(wd), .o_pc(o_pc), .o_fetch_addr(fetch),
        .o_data_addr(daddr), .o_area(area), .o_bank(bank), .o_rdata(rdata),
        .o_rvalid(rvalid), .o_sfr_wr(sfr_wr), .o_indirect_pointer(ptr_o));

    task automatic chk(input string n, input logic [12:0] e,
                       input logic [12:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    // Top shared offsets land in one place whatever the bank
    function automatic logic [7:0] key(input logic b, input logic [6:0] a);
        return (a >= 7'h70) ? {1'b0, a} : {b, a};
    endfunction

    task automatic wrt(input logic [6:0] a, input logic [7:0] v,
                       input logic i);
        if (i) mem[key(ptr[7], ptr[6:0])] = v;
        else if (a == `OFS_STATUS) bsl = v[5];
        else if (a == `OFS_POINTER) ptr = v;
        else mem[key(bsl, a)] = v;
        u_core.op({4'h0, 1'b1, i}, 0, a, v);
        @(negedge i_clk);
    endtask

    task automatic rdx(input logic [6:0] a, input logic i,
                       input logic [7:0] e);
        exp_q.push_back(e);
        u_core.op({3'h0, 1'b1, 1'b0, i}, 0, a, 0);
        @(negedge i_clk);
    endtask

    // ****************************************************************
    // Read results are matched in order against the noted values
    // ****************************************************************
    always @(negedge i_clk) begin
        if (rvalid === 1'b1) begin
            // An answer with nothing noted compares against unknown
            d = exp_q.size() ? exp_q.pop_front() : 'x;
            chk("rdata", 13'(d), 13'(rdata));
        end
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Watchdog well past the fewer than one hundred cycles the tests need
    initial begin
        #20000;
        err_total++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(95));
        repeat (3) @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(negedge i_clk);
        chk("pc", 13'h0000, o_pc);
        // Steps, jumps past 4K and interrupt priority
        for (int k = 0; k < 6; k++) begin
            u_core.op(pf[k], pt[k], 0, 0);
            @(negedge i_clk);
            chk("pc", pe[k], o_pc);
            chk("fetch", 13'(pe[k][11:0]), 13'(fetch));
        end
        // Every bank selected, RAM bottom and shared top written
        for (int b = 0; b < 4; b++) begin
            wrt(`OFS_STATUS, {1'b0, 2'(b), 5'h18}, 0);
            chk("area", 13'h1, 13'(area));
            rdx(`OFS_STATUS, 0, {1'b0, 2'(b), 5'h18});
            wrt(7'h20, 8'($urandom), 0);
            chk("sfr_wr", 13'h0, 13'(sfr_wr));
            chk("bank", 13'(b), 13'(bank));
            chk("daddr", 13'({2'(b), 7'h20}), 13'(daddr));
            wrt(7'h7F, 8'($urandom), 0);
            chk("area", 13'h3, 13'(area));
        end
        wrt(`OFS_STATUS, 8'h18, 0);
        rdx(7'h20, 0, mem[key(0, 7'h20)]);
        rdx(7'h7F, 0, mem[key(0, 7'h7F)]);
        rdx(7'h05, 0, 8'h00);
        chk("area", 13'h2, 13'(area));
        wrt(7'h05, 8'h5A, 0);
        chk("sfr_wr", 13'h1, 13'(sfr_wr));
        rdx(`OFS_PCL, 0, pe[5][7:0]);
        // Pointer access into bank 1 RAM, then a write through it and a read back
        wrt(`OFS_POINTER, 8'hA0, 0);
        chk("ptr", 13'h0A0, 13'(ptr_o));
        rdx(7'h00, 1, mem[key(1, 7'h20)]);
        chk("daddr", 13'h0A0, 13'(daddr));
        wrt(7'h00, 8'($urandom), 1);
        rdx(7'h00, 1, mem[key(1, 7'h20)]);
        // Upper bank bit set: pointer reaches the same folded RAM byte
        wrt(`OFS_STATUS, 8'h98, 0);
        rdx(7'h00, 1, mem[key(1, 7'h20)]);
        chk("daddr", 13'h1A0, 13'(daddr));
        wrt(`OFS_POINTER, 8'h00, 0);
        rdx(7'h00, 1, 8'h00);
        repeat (3) @(negedge i_clk);
        chk("pending", 13'h0, 13'(exp_q.size()));
        tally_and_finish();
    end
endmodule
